// >>> dv/dsl_slew_assertions.sv
`timescale 1ns/1ps

// Port-level checks of the bus answer and of the reset state.
module dsl_slew_checker (
	// Clock and reset.
	input wire        clk,
	input wire        rst,
	// Bus side.
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	// Converter side.
	input wire [63:0] dac_code,
	input wire [3:0]  slew_busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// A setup cycle and then the access phase.
	sequence setup_access_s;
		psel && !penable ##1 psel && penable;
	endsequence

	// A clear walk may hold the answer back by some ten cycles.
	bus_answer_a: assert property (setup_access_s |-> ##[1:16] pready)
		else $error("bus access not answered");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	ready_cause_a: assert property (pready |-> psel && penable && $past(penable))
		else $error("pready without an access phase");
	idle_rdata_a: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("read data outside an answer");
	err_ready_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("error without answer or with data");
	bad_addr_a: assert property (pready && (paddr[7] || paddr[1:0] != 2'h0) |-> pslverr)
		else $error("unmapped address accepted");
	ro_write_a: assert property (pready && pwrite && paddr[6:4] == 3'h3 |-> pslverr)
		else $error("write to present code accepted");
	read_width_a: assert property (pready && !pwrite && paddr[6:4] != 3'h1 |->
		prdata[31:16] == 16'h0000)
		else $error("code read has upper bits set");
	reset_out_a: assert property ($fell(rst) |-> dac_code == 64'h0 && slew_busy == 4'h0)
		else $error("outputs not cleared by reset");
endmodule // dsl_slew_checker

bind dsl_slew_limiter dsl_slew_checker dsl_slew_checker_inst (
	.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.dac_code(dac_code), .slew_busy(slew_busy));

// >>> dv/dsl_slew_limiter_test.sv
`timescale 1ns/1ps

module dsl_slew_limiter_test;
	// Design inputs, all driven by the bench.
	reg         clk, rst, psel, penable, pwrite, osc_13m, clear_in;
	reg  [7:0]  paddr;
	reg  [31:0] pwdata;
	// Design outputs.
	wire [31:0] prdata;
	wire        pready, pslverr;
	wire [63:0] dac_code;
	wire [3:0]  slew_busy;
	// Bookkeeping.
	integer     n_fail, check_count, i;
	integer     cycles = 0;
	reg  [31:0] rd;
	reg         err;
	// Bench copy of the channel 1 code, so no expectation comes from the design.
	reg  [15:0] code1;

	dsl_slew_limiter dsl_slew_limiter_inst (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_13m(osc_13m),
		.clear_in(clear_in), .dac_code(dac_code), .slew_busy(slew_busy));

	// System clock of 100 MHz.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Oscillator pin near 13 MHz, unrelated in phase to clk.
	initial begin
		osc_13m = 1'b0;
		forever #38.462 osc_13m = ~osc_13m;
	end

	task check_eq(input [31:0] got, input [31:0] exp);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask

	task test_done;
		begin
			$display("checks %0d mismatches %0d", check_count, n_fail);
			if (n_fail == 0 && check_count > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask

	// One bus transfer; the request stands until pready is seen high or 64 wait cycles pass.
	task apb(input wr, input [7:0] a, input [31:0] wd);
		integer n;
		begin
			@(posedge clk);
			psel <= 1'b1;
			pwrite <= wr;
			paddr <= a;
			pwdata <= wd;
			@(posedge clk);
			penable <= 1'b1;
			@(posedge clk);
			n = 0;
			while (pready !== 1'b1 && n < 64) begin
				@(posedge clk);
				n = n + 1;
			end
			check_eq({31'h0, pready}, 32'h1);
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	// Waits, bounded, for the code of one channel to move.
	task wait_code(input [1:0] ch, output [15:0] v, output integer t);
		reg [15:0] old;
		integer    n;
		begin
			old = dac_code[ch*16 +: 16];
			n = 0;
			while (dac_code[ch*16 +: 16] === old && n < 4000) begin
				@(posedge clk);
				n = n + 1;
			end
			v = dac_code[ch*16 +: 16];
			t = cycles;
		end
	endtask

	// Reset values, read-only and unmapped places.
	task test_regs;
		reg [31:0] bad;
		begin
			bad = 32'h8042_5044;
			for (i = 0; i < 5; i = i + 1) begin
				apb(1'b0, {i[3:0], 4'h0}, 32'h0);
				check_eq({31'h0, err}, 32'h0);
				check_eq(rd, 32'h0);
			end
			for (i = 0; i < 4; i = i + 1) begin
				apb(1'b0, bad[8*i +: 8], 32'h0);
				check_eq({31'h0, err}, 32'h1);
			end
			apb(1'b1, 8'h34, 32'h1234);
			check_eq({31'h0, err}, 32'h1);
			apb(1'b0, 8'h34, 32'h0);
			check_eq(rd, 32'h0);
			// Unused configuration bits read back as zero.
			apb(1'b1, 8'h1c, 32'hffff_ffff);
			apb(1'b0, 8'h1c, 32'h0);
			check_eq(rd, 32'h0000_01ff);
			apb(1'b1, 8'h1c, 32'h0);
			$display("test regs done");
		end
	endtask

	// Every step size on channel 1, with rate code 1 for the last one.
	task test_step;
		reg [15:0] lsb, tgt, v, exp;
		integer    s, k, t, tp, per;
		begin
			for (s = 0; s < 8; s = s + 1) begin
				lsb = (s < 3) ? (16'h1 << s) : (16'h1 << (s + 1));
				per = (s == 7) ? 3125 : 1562;
				apb(1'b1, 8'h14, {23'h0, 1'b0, s[2:0], 3'h0, (s == 7), 1'b1});
				tgt = code1 + 2 * lsb + 16'h1;
				apb(1'b1, 8'h04, {16'h0, tgt});
				for (k = 0; k < 3; k = k + 1) begin
					wait_code(2'h1, v, t);
					exp = (tgt - code1 > lsb) ? code1 + lsb : tgt;
					check_eq(v, exp);
					if (k == 0)
						check_eq({31'h0, slew_busy[1]}, 32'h1);
					else
						check_eq({31'h0, (t - tp > per - 80) && (t - tp < per + 80)}, 32'h1);
					code1 = exp;
					tp = t;
				end
				repeat (3) @(posedge clk);
				check_eq(dac_code[31:16], tgt);
				check_eq({31'h0, slew_busy[1]}, 32'h0);
			end
			$display("test step done");
		end
	endtask

	// Jump with slew off, then a stepped clear downward; channel 3 not allowed.
	task test_clear;
		reg [15:0] v;
		integer    k, t;
		begin
			apb(1'b1, 8'h08, 32'h0500);
			repeat (2) @(posedge clk);
			check_eq(dac_code[47:32], 16'h0500);
			apb(1'b1, 8'h0c, 32'h0abc);
			apb(1'b1, 8'h2c, 32'h0111);
			apb(1'b1, 8'h28, 32'h0280);
			apb(1'b1, 8'h18, 32'h01e1);
			@(posedge clk);
			// host care: clear is raised only while no channel is mid-slew.
			check_eq({28'h0, slew_busy}, 32'h0);
			clear_in <= 1'b1;
			repeat (4) @(posedge clk);
			clear_in <= 1'b0;
			for (k = 0; k < 3; k = k + 1) begin
				wait_code(2'h2, v, t);
				check_eq(v, (k == 2) ? 16'h0280 : 16'h0400 - 16'h0100 * k);
			end
			check_eq(dac_code[63:48], 16'h0abc);
			apb(1'b0, 8'h0c, 32'h0);
			check_eq(rd, 32'h0abc);
			apb(1'b0, 8'h08, 32'h0);
			check_eq(rd, 32'h0280);
			$display("test clear done");
		end
	endtask

	// Main sequence.
	initial begin
		n_fail = 0;
		check_count = 0;
		code1 = 16'h0;
		rst = 1'b1;
		{psel, penable, pwrite, clear_in} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		test_regs;
		test_step;
		test_clear;
		test_done;
	end

	// The steps take some 40000 cycles; this ceiling cuts a hang short.
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 90000) begin
			n_fail = n_fail + 1;
			test_done;
		end
	end
endmodule // dsl_slew_limiter_test

// >>> verilog/dsl_code_mem.v
`timescale 1ns/1ps

// Four-entry store of the per-channel clear codes, registered read data.
module dsl_code_mem (
	// Clock and reset.
	input  wire        clk,
	input  wire        rst,
	// Write port.
	input  wire        wr_en,
	input  wire [1:0]  wr_addr,
	input  wire [15:0] wr_data,
	// Read port, data one cycle after the address.
	input  wire [1:0]  rd_addr,
	output reg  [15:0] rd_data
);

	reg [15:0] mem_q [0:3];  // Clear code per channel.
	integer    i;            // Reset loop index.

	// Storage is reset to zero so a clear before programming is defined.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			for (i = 0; i < 4; i = i + 1) begin
				mem_q[i] <= 16'h0000;
			end
		end else if (wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
	end

	// Read data comes out of a register.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data <= 16'h0000;
		end else begin
			rd_data <= mem_q[rd_addr];
		end
	end

endmodule // dsl_code_mem

// >>> verilog/dsl_map.vh
`ifndef DSL_MAP_VH
`define DSL_MAP_VH

// Register regions, selected by paddr[6:4]; paddr[3:2] picks the channel.
`define DSL_RGN_TARGET   3'h0
`define DSL_RGN_CFG      3'h1
`define DSL_RGN_CLRCODE  3'h2
`define DSL_RGN_CODE     3'h3
`define DSL_RGN_STATUS   3'h4
`define DSL_RGN_LSB      4
`define DSL_RGN_MSB      6
`define DSL_CH_LSB       2
`define DSL_CH_MSB       3
`define DSL_ADDR_TOP     7

// Slew configuration register fields.
`define DSL_CFG_W        9
`define DSL_CFG_EN       0
`define DSL_CFG_TICK_LSB 1
`define DSL_CFG_TICK_MSB 4
`define DSL_CFG_STEP_LSB 5
`define DSL_CFG_STEP_MSB 7
`define DSL_CFG_CLRALLOW 8

// Reset values.
`define DSL_CFG_RST      9'h000
`define DSL_CODE_RST     16'h0000
`define DSL_DATA_ZERO    32'h0000_0000

// Internal oscillator and the fastest update rate, in Hz.
`define DSL_OSC_HZ       24'hc6_5d40
`define DSL_BASE_HZ      24'h00_fa00

// Base ticks per update for the slower, non power-of-two rate codes, and the unit that codes up to 9 shift.
`define DSL_DIV_64HZ     17'h003e8
`define DSL_DIV_32HZ     17'h007d0
`define DSL_DIV_16HZ     17'h00fa0
`define DSL_DIV_8HZ      17'h01f40
`define DSL_DIV_4HZ      17'h03e80
`define DSL_DIV_HALFHZ   17'h1f400
`define DSL_DIV_ONE      17'h00001

// Last channel index.
`define DSL_CH_LAST      2'h3

`endif

// >>> verilog/dsl_slew_limiter.v
`timescale 1ns/1ps
`include "dsl_map.vh"

module dsl_slew_limiter (
	// Clock and reset.
	input  wire        clk,
	input  wire        rst,
	// APB slave.
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// Pins from outside the clock domain.
	input  wire        osc_13m,
	input  wire        clear_in,
	// Output codes to the four converters, channel 0 in the low bits.
	output wire [63:0] dac_code,
	output wire [3:0]  slew_busy
);

	// Walker states, one-hot.
	localparam [2:0] CW_IDLE = 3'b001;
	localparam [2:0] CW_READ = 3'b010;
	localparam [2:0] CW_LOAD = 3'b100;

	// Step size in LSBs for a step code.
	function [15:0] step_lsb;
		input [2:0] sel;
		begin
			case (sel)
				3'h0:    step_lsb = 16'h0001;
				3'h1:    step_lsb = 16'h0002;
				3'h2:    step_lsb = 16'h0004;
				3'h3:    step_lsb = 16'h0010;
				3'h4:    step_lsb = 16'h0020;
				3'h5:    step_lsb = 16'h0040;
				3'h6:    step_lsb = 16'h0080;
				default: step_lsb = 16'h0100;
			endcase
		end
	endfunction

	// Base ticks per update; codes up to 9 are powers of two.
	function [16:0] div_count;
		input [3:0] sel;
		begin
			case (sel)
				4'ha:    div_count = `DSL_DIV_64HZ;
				4'hb:    div_count = `DSL_DIV_32HZ;
				4'hc:    div_count = `DSL_DIV_16HZ;
				4'hd:    div_count = `DSL_DIV_8HZ;
				4'he:    div_count = `DSL_DIV_4HZ;
				4'hf:    div_count = `DSL_DIV_HALFHZ;
				default: div_count = `DSL_DIV_ONE << sel;
			endcase
		end
	endfunction

	// One step from cur toward tgt, saturating on the target.
	function [15:0] step_toward;
		input [15:0] cur;
		input [15:0] tgt;
		input [15:0] stp;
		reg   [16:0] gap;
		begin
			gap = 17'h00000;
			if (tgt > cur) begin
				gap = {1'b0, tgt} - {1'b0, cur};
				step_toward = (gap <= {1'b0, stp}) ? tgt : cur + stp;
			end else begin
				gap = {1'b0, cur} - {1'b0, tgt};
				step_toward = (gap <= {1'b0, stp}) ? tgt : cur - stp;
			end
		end
	endfunction

	// Synchronisers and edge memories for the two pins.
	reg         osc_s1_q;       // First stage, read only by the second.
	reg         osc_s2_q;       // Synchronised oscillator level.
	reg         osc_s3_q;       // Previous level for edge detection.
	reg         clr_s1_q;       // First stage, read only by the second.
	reg         clr_s2_q;       // Synchronised clear level.
	reg         clr_s3_q;       // Previous level for edge detection.

	// Update-rate generation.
	reg  [23:0] acc_q;          // Phase accumulator in Hz units.
	reg         base_tick_q;    // One pulse per 64 kHz period.
	wire [23:0] acc_sum;        // Accumulator after one oscillator edge.

	// Clear walker.
	reg  [2:0]  cw_state_q;     // Walker state.
	reg  [1:0]  cw_ch_q;        // Channel being handled.
	reg         clr_pend_q;     // Clear edge seen, walk not yet started.
	reg         cw_idle_prev_q; // Walker was idle in the previous cycle.

	// Bus side.
	reg  [31:0] prdata_q;       // Read data held for the access.
	reg         pready_q;       // Access completes this cycle.
	reg         pslverr_q;      // Error answer: unmapped address or read-only write.
	reg  [31:0] rd_mux;         // Read data for the addressed register.
	reg         rd_bad;         // Address is unmapped or read-only write.
	wire [2:0]  rgn;            // Addressed region.
	wire [1:0]  ch_sel;         // Addressed channel.
	wire        apb_wr;         // Write takes effect this edge.
	wire        cw_idle;        // Walker holds no memory read slot.
	wire [15:0] mem_rdata;      // Clear code read data.
	wire [1:0]  mem_raddr;      // Clear code read address.

	// Per-channel state gathered for the read mux.
	wire [63:0] tgt_all;        // Targets.
	wire [35:0] cfg_all;        // Slew configurations.
	wire [63:0] code_all;       // Present output codes.
	wire [3:0]  busy_all;       // Slewing flags.

	assign rgn     = paddr[`DSL_RGN_MSB:`DSL_RGN_LSB];
	assign ch_sel  = paddr[`DSL_CH_MSB:`DSL_CH_LSB];
	assign cw_idle = cw_state_q[0];
	assign apb_wr  = psel & penable & pready_q & pwrite & ~pslverr_q;

	// Walker owns the read port while active, otherwise the bus address does.
	assign mem_raddr = cw_idle ? ch_sel : cw_ch_q;

	assign prdata    = prdata_q;
	assign pready    = pready_q;
	assign pslverr   = pslverr_q;
	assign dac_code  = code_all;
	assign slew_busy = busy_all;

	// Both pins pass two flip-flops before any logic reads them.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			osc_s1_q <= 1'b0;
			osc_s2_q <= 1'b0;
			osc_s3_q <= 1'b0;
			clr_s1_q <= 1'b0;
			clr_s2_q <= 1'b0;
			clr_s3_q <= 1'b0;
		end else begin
			osc_s1_q <= osc_13m;
			osc_s2_q <= osc_s1_q;
			osc_s3_q <= osc_s2_q;
			clr_s1_q <= clear_in;
			clr_s2_q <= clr_s1_q;
			clr_s3_q <= clr_s2_q;
		end
	end

	assign acc_sum = acc_q + `DSL_BASE_HZ;

	// oscillator divide: 64 kHz from 13 MHz edges.
	// range independent: no range term enters the divide.
	// A fractional accumulator is used since 13 MHz / 64 kHz is not whole;
	// the base tick jitters by one oscillator period but averages exactly.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			acc_q       <= 24'h00_0000;
			base_tick_q <= 1'b0;
		end else begin
			base_tick_q <= 1'b0;
			if (osc_s2_q & ~osc_s3_q) begin
				if (acc_sum >= `DSL_OSC_HZ) begin
					acc_q       <= acc_sum - `DSL_OSC_HZ;
					base_tick_q <= 1'b1;
				end else begin
					acc_q <= acc_sum;
				end
			end
		end
	end

	// clear edge: rising edge sets a pending walk.
	// Set wins over the clear taken when the walk starts, so an edge is
	// never lost; a second edge during a walk starts one more walk.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			clr_pend_q <= 1'b0;
		end else if (clr_s2_q & ~clr_s3_q) begin
			clr_pend_q <= 1'b1;
		end else if (cw_idle) begin
			clr_pend_q <= 1'b0;
		end
	end

	// Walker reads each channel's clear code in turn, two cycles each.
	// Channels are reloaded a few cycles apart, far below any tick period.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cw_state_q     <= CW_IDLE;
			cw_ch_q        <= 2'h0;
			cw_idle_prev_q <= 1'b1;
		end else begin
			cw_idle_prev_q <= cw_idle;
			case (cw_state_q)
				CW_IDLE: begin
					cw_ch_q <= 2'h0;
					if (clr_pend_q) begin
						cw_state_q <= CW_READ;
					end
				end
				CW_READ: begin
					cw_state_q <= CW_LOAD;
				end
				CW_LOAD: begin
					// Last channel ends the walk.
					if (cw_ch_q == `DSL_CH_LAST) begin
						cw_state_q <= CW_IDLE;
					end else begin
						cw_ch_q    <= cw_ch_q + 2'h1;
						cw_state_q <= CW_READ;
					end
				end
				default: begin
					cw_state_q <= CW_IDLE;
				end
			endcase
		end
	end

	dsl_code_mem u_code_mem (
		.clk     (clk),
		.rst     (rst),
		.wr_en   (apb_wr && (rgn == `DSL_RGN_CLRCODE)),
		.wr_addr (ch_sel),
		.wr_data (pwdata[15:0]),
		.rd_addr (mem_raddr),
		.rd_data (mem_rdata)
	);

	// Per-channel target, configuration, rate divider and stepping.
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : chan
			localparam [1:0] IDX = g;
			reg  [15:0] target_q;  // Code the output is heading for.
			reg  [8:0]  cfg_q;     // Slew configuration.
			reg  [15:0] code_q;    // Present output code.
			reg  [16:0] div_q;     // Base ticks left to the next update.
			reg         busy_q;    // Output not yet on target.
			wire        tick;      // Update instant for this channel.
			wire        hit;       // Bus addresses this channel.

			assign hit  = (ch_sel == IDX);
			assign tick = base_tick_q && (div_q == 17'h00000);

			// Configuration written by software.
			always @(posedge clk or posedge rst) begin
				if (rst) begin
					cfg_q <= `DSL_CFG_RST;
				end else if (apb_wr && hit && (rgn == `DSL_RGN_CFG)) begin
					cfg_q <= pwdata[`DSL_CFG_W-1:0];
				end
			end

			// Target from software or from the clear walk.
			always @(posedge clk or posedge rst) begin
				if (rst) begin
					target_q <= `DSL_CODE_RST;
				// clear allow: others keep their target.
				end else if (cw_state_q[2] && (cw_ch_q == IDX) &&
					cfg_q[`DSL_CFG_CLRALLOW]) begin
					// clear target: stepping then applies as usual.
					target_q <= mem_rdata;
				end else if (apb_wr && hit && (rgn == `DSL_RGN_TARGET)) begin
					target_q <= pwdata[15:0];
				end
			end

			// rate select: reload with the chosen divide.
			always @(posedge clk or posedge rst) begin
				if (rst) begin
					div_q <= 17'h00000;
				end else if (base_tick_q) begin
					if (div_q == 17'h00000) begin
						div_q <= div_count(cfg_q[`DSL_CFG_TICK_MSB:`DSL_CFG_TICK_LSB])
							- 17'h00001;
					end else begin
						div_q <= div_q - 17'h00001;
					end
				end
			end

			// slew enable: picks direct or stepped update.
			// all sources stepped: clear and bus share one target.
			always @(posedge clk or posedge rst) begin
				if (rst) begin
					code_q <= `DSL_CODE_RST;
				end else if (!cfg_q[`DSL_CFG_EN]) begin
					// direct update: one cycle to target.
					code_q <= target_q;
				end else if (tick && (code_q != target_q)) begin
					// stepped update: one step per tick.
					// step size: table of LSB counts.
					// code LSBs: step is in codes, not current.
					// slew duration: change over step times rate.
					// saturate step: lands exactly on target.
					code_q <= step_toward(code_q, target_q,
						step_lsb(cfg_q[`DSL_CFG_STEP_MSB:`DSL_CFG_STEP_LSB]));
				end
			end

			// Busy flag trails the code by one cycle.
			always @(posedge clk or posedge rst) begin
				if (rst) begin
					busy_q <= 1'b0;
				end else begin
					busy_q <= (code_q != target_q);
				end
			end

			assign tgt_all[16*g +: 16]  = target_q;
			assign cfg_all[9*g +: 9]    = cfg_q;
			assign code_all[16*g +: 16] = code_q;
			assign busy_all[g]          = busy_q;
		end
	endgenerate

	// Read mux and unmapped-address decode.
	always @* begin
		rd_mux = `DSL_DATA_ZERO;
		rd_bad = 1'b0;
		if (paddr[`DSL_ADDR_TOP] || (paddr[1:0] != 2'h0)) begin
			rd_bad = 1'b1;
		end else begin
			case (rgn)
				`DSL_RGN_TARGET:  rd_mux[15:0] = tgt_all[16*ch_sel +: 16];
				`DSL_RGN_CFG:     rd_mux[8:0]  = cfg_all[9*ch_sel +: 9];
				`DSL_RGN_CLRCODE: rd_mux[15:0] = mem_rdata;
				`DSL_RGN_CODE: begin
					rd_mux[15:0] = code_all[16*ch_sel +: 16];
					rd_bad       = pwrite;
				end
				`DSL_RGN_STATUS: begin
					rd_mux[3:0] = busy_all;
					rd_bad      = pwrite || (ch_sel != 2'h0);
				end
				default: rd_bad = 1'b1;
			endcase
		end
	end

	// APB answer: one wait state, longer while the walker holds the
	// clear-code read port, so that code reads always see fresh data.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pready_q  <= 1'b0;
			prdata_q  <= `DSL_DATA_ZERO;
			pslverr_q <= 1'b0;
		end else if (psel && penable && !pready_q && cw_idle && cw_idle_prev_q) begin
			pready_q  <= 1'b1;
			pslverr_q <= rd_bad;
			prdata_q  <= (pwrite || rd_bad) ? `DSL_DATA_ZERO : rd_mux;
		end else begin
			// Read data is dropped with the answer, so a stale word never lingers.
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= `DSL_DATA_ZERO;
		end
	end

endmodule // dsl_slew_limiter
